// >>> ppp_cfg.svh
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPP_OFF_DATA 12'h000
`define PPP_OFF_STATUS 12'h004
`define PPP_OFF_CTRL 12'h008
`define PPP_OFF_IRQ_STAT 12'h00C
`define PPP_OFF_IRQ_EN 12'h010
`define PPP_OFF_IRQ_CLR 12'h014
// ----------------------------------------
// control register fields
// ----------------------------------------
`define PPP_CTRL_STROBE 0
`define PPP_CTRL_AUTOFD 1
`define PPP_CTRL_INIT 2
`define PPP_CTRL_SELECT 3
`define PPP_CTRL_DIR 5
`define PPP_CTRL_PORT_EN 6
// ----------------------------------------
// status register fields
// ----------------------------------------
`define PPP_STAT_ERROR_N 3
`define PPP_STAT_SELECTED 4
`define PPP_STAT_PAPER_OUT 5
`define PPP_STAT_ACK_N 6
`define PPP_STAT_BUSY 7
// ----------------------------------------
// interrupt status fields
// ----------------------------------------
`define PPP_IRQ_ACK 0
`define PPP_IRQ_ERROR 1
`define PPP_IRQ_PAPER 2
`define PPP_IRQ_W 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define PPP_CTRL_RST 8'h04
`define PPP_DATA_RST 8'h00
`endif

// >>> ppp_pkg.sv
package ppp_pkg;
	// sampled printer input vector order
	typedef enum logic [2:0]
	{
		PPP_IN_SEL = 3'h0,
		PPP_IN_PAPER = 3'h1,
		PPP_IN_BUSY = 3'h2,
		PPP_IN_ACK = 3'h3,
		PPP_IN_ERR = 3'h4
	} ppp_in_t;
endpackage

// >>> ppp_port.sv
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ppp_cfg.svh"
module ppp_port
	import ppp_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// printer status inputs
	input wire logic printer_selected_in,
	input wire logic paper_out_in,
	input wire logic busy_in,
	input wire logic ack_in_n,
	input wire logic error_in_n,
	// printer control outputs
	output logic data_strobe_n,
	output logic line_feed_auto_n,
	output logic init_out_n,
	output logic select_request_n,
	// printer data bus, three signals
	input wire logic [7:0] printer_data_bus_i,
	output logic [7:0] printer_data_bus_o,
	output logic [7:0] printer_data_bus_oe,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NIN = 5;
	logic [NIN-1:0] raw_in; // pin levels
	logic [NIN-1:0] s1_r, s2_r, s3_r, st_r; // chain and settled
	logic [NIN-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;
	logic [7:0] st_wide; // settle result before trimming to the pin count
	logic [7:0] din1_r, din2_r, din3_r, dinst_r; // data bus readback
	logic [7:0] din1_nxt, din2_nxt, din3_nxt, dinst_nxt;
	assign raw_in[PPP_IN_SEL] = printer_selected_in;
	assign raw_in[PPP_IN_PAPER] = paper_out_in;
	assign raw_in[PPP_IN_BUSY] = busy_in;
	assign raw_in[PPP_IN_ACK] = ack_in_n;
	assign raw_in[PPP_IN_ERR] = error_in_n;
	// settle a bit once stages two and three agree
	function automatic logic [7:0] settle(input logic [7:0] a, input logic [7:0] b, input logic [7:0] old);
		settle = (a & b) | (old & (a | b));
	endfunction
	// next values of the chains
	always_comb
	begin
		s1_nxt = raw_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		st_wide = settle({3'h0, s2_r}, {3'h0, s3_r}, {3'h0, st_r});
		st_nxt = st_wide[NIN-1:0];
		din1_nxt = printer_data_bus_i;
		din2_nxt = din1_r;
		din3_nxt = din2_r;
		dinst_nxt = settle(din2_r, din3_r, dinst_r);
	end
	// chain registers; idle pin levels at reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// idle levels: ack and error high, others low
			s1_r <= 5'h18;
			s2_r <= 5'h18;
			s3_r <= 5'h18;
			st_r <= 5'h18;
			din1_r <= 8'h00;
			din2_r <= 8'h00;
			din3_r <= 8'h00;
			dinst_r <= 8'h00;
		end
		else
		begin
			// shift every chain one stage
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			st_r <= st_nxt;
			din1_r <= din1_nxt;
			din2_r <= din2_nxt;
			din3_r <= din3_nxt;
			dinst_r <= dinst_nxt;
		end
	end
	// ----------------------------------------
	// registers and apb
	// ----------------------------------------
	logic [7:0] ctrl_r, ctrl_nxt; // printer control
	logic [7:0] data_r, data_nxt; // output data latch
	logic [`PPP_IRQ_W-1:0] ist_r, ist_nxt; // sticky events
	logic [`PPP_IRQ_W-1:0] ien_r, ien_nxt; // event enables
	logic [NIN-1:0] stp_r, stp_nxt; // previous settled levels
	logic [31:0] rd_r, rd_nxt; // read data
	logic [`PPP_IRQ_W-1:0] ev; // event pulses
	logic [7:0] status; // status byte
	logic wr, rd;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = rd_r;
	// status byte built from settled levels
	always_comb
	begin
		status = 8'h00;
		status[`PPP_STAT_ERROR_N] = st_r[PPP_IN_ERR];
		status[`PPP_STAT_SELECTED] = st_r[PPP_IN_SEL];
		status[`PPP_STAT_PAPER_OUT] = st_r[PPP_IN_PAPER];
		status[`PPP_STAT_ACK_N] = st_r[PPP_IN_ACK];
		status[`PPP_STAT_BUSY] = st_r[PPP_IN_BUSY];
	end
	// events: ack falling edge, error falling, paper out rising
	always_comb
	begin
		ev = '0;
		ev[`PPP_IRQ_ACK] = stp_r[PPP_IN_ACK] & ~st_r[PPP_IN_ACK];
		ev[`PPP_IRQ_ERROR] = stp_r[PPP_IN_ERR] & ~st_r[PPP_IN_ERR];
		ev[`PPP_IRQ_PAPER] = ~stp_r[PPP_IN_PAPER] & st_r[PPP_IN_PAPER];
	end
	// next register values; read data captured in setup
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		data_nxt = data_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		stp_nxt = st_r;
		rd_nxt = rd_r;
		if (wr)
		begin
			case (paddr)
				`PPP_OFF_DATA: data_nxt = pwdata[7:0];
				`PPP_OFF_CTRL: ctrl_nxt = pwdata[7:0];
				`PPP_OFF_IRQ_EN: ien_nxt = pwdata[`PPP_IRQ_W-1:0];
				`PPP_OFF_IRQ_CLR: ist_nxt = ist_r & ~pwdata[`PPP_IRQ_W-1:0];
				default: ;
			endcase
		end
		// set wins over a same-cycle clear
		ist_nxt = ist_nxt | ev;
		if (rd)
		begin
			case (paddr)
				`PPP_OFF_DATA: rd_nxt = {24'h00_0000, ctrl_r[`PPP_CTRL_DIR] ? dinst_r : data_r};
				`PPP_OFF_STATUS: rd_nxt = {24'h00_0000, status};
				`PPP_OFF_CTRL: rd_nxt = {24'h00_0000, ctrl_r};
				`PPP_OFF_IRQ_STAT: rd_nxt = {29'h0000_0000, ist_r};
				`PPP_OFF_IRQ_EN: rd_nxt = {29'h0000_0000, ien_r};
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end
	// register state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// pins released, bus floating, no events
			ctrl_r <= `PPP_CTRL_RST;
			data_r <= `PPP_DATA_RST;
			ien_r <= 3'h0;
			ist_r <= 3'h0;
			stp_r <= 5'h18;
			rd_r <= 32'h0000_0000;
		end
		else
		begin
			// take the computed next values
			ctrl_r <= ctrl_nxt;
			data_r <= data_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			stp_r <= stp_nxt;
			rd_r <= rd_nxt;
		end
	end
	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	assign data_strobe_n = ~ctrl_r[`PPP_CTRL_STROBE];
	assign line_feed_auto_n = ~ctrl_r[`PPP_CTRL_AUTOFD];
	assign init_out_n = ctrl_r[`PPP_CTRL_INIT];
	assign select_request_n = ~ctrl_r[`PPP_CTRL_SELECT];
	assign printer_data_bus_o = data_r;
	// drive only when enabled and in output direction
	assign printer_data_bus_oe = {8{ctrl_r[`PPP_CTRL_PORT_EN] & ~ctrl_r[`PPP_CTRL_DIR]}};
	assign irq = |(ist_r & ien_r);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_strobe_map: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL) |=> data_strobe_n == !$past(pwdata[`PPP_CTRL_STROBE]))
		else $error("strobe mismatch");
	chk_autofd_map: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL) |=> line_feed_auto_n == !$past(pwdata[`PPP_CTRL_AUTOFD]))
		else $error("autofeed mismatch");
	chk_init_map: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL) |=> init_out_n == $past(pwdata[`PPP_CTRL_INIT]))
		else $error("init mismatch");
	chk_select_map: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL) |=> select_request_n == !$past(pwdata[`PPP_CTRL_SELECT]))
		else $error("select mismatch");
	chk_pins_stable: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && paddr == `PPP_OFF_CTRL) |=> $stable({data_strobe_n, line_feed_auto_n, init_out_n, select_request_n}))
		else $error("control pins moved without write");
	chk_bus_float: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_r[`PPP_CTRL_PORT_EN] |-> printer_data_bus_oe == 8'h00)
		else $error("bus driven while off");
	chk_oe_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL && pwdata[`PPP_CTRL_PORT_EN] && !pwdata[`PPP_CTRL_DIR]) |=> printer_data_bus_oe == 8'hFF)
		else $error("bus not driven");
	chk_oe_listen: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_CTRL && pwdata[`PPP_CTRL_DIR]) |=> printer_data_bus_oe == 8'h00)
		else $error("bus driven while listening");
	chk_bus_value: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_DATA) |=> printer_data_bus_o == $past(pwdata[7:0]))
		else $error("bus data mismatch");
	// ----------------------------------------
	// status read checks
	// ----------------------------------------
	chk_error_status: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[`PPP_STAT_ERROR_N] == $past(st_r[PPP_IN_ERR]))
		else $error("error bit");
	chk_busy_status: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[`PPP_STAT_BUSY] == $past(st_r[PPP_IN_BUSY]))
		else $error("busy bit");
	chk_sel_status: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[`PPP_STAT_SELECTED] == $past(st_r[PPP_IN_SEL]))
		else $error("select bit");
	chk_paper_status: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[`PPP_STAT_PAPER_OUT] == $past(st_r[PPP_IN_PAPER]))
		else $error("paper bit");
	chk_ack_status: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[`PPP_STAT_ACK_N] == $past(st_r[PPP_IN_ACK]))
		else $error("ack bit");
	chk_status_spare: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == `PPP_OFF_STATUS) |=> prdata[31:8] == 24'h00_0000 && prdata[2:0] == 3'h0)
		else $error("spare status bits set");
	// ----------------------------------------
	// input settle checks
	// ----------------------------------------
	chk_sel_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(printer_selected_in [*5]) |-> st_r[PPP_IN_SEL])
		else $error("select not settled");
	chk_sel_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(!printer_selected_in [*5]) |-> !st_r[PPP_IN_SEL])
		else $error("select not released");
	chk_paper_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(paper_out_in [*5]) |-> st_r[PPP_IN_PAPER])
		else $error("paper not settled");
	chk_paper_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(!paper_out_in [*5]) |-> !st_r[PPP_IN_PAPER])
		else $error("paper not released");
	chk_busy_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(busy_in [*5]) |-> st_r[PPP_IN_BUSY])
		else $error("busy not settled");
	chk_busy_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(!busy_in [*5]) |-> !st_r[PPP_IN_BUSY])
		else $error("busy not released");
	chk_ack_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(!ack_in_n [*2]) |=> ##2 !st_r[PPP_IN_ACK])
		else $error("short ack pulse lost");
	chk_err_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(!error_in_n [*5]) |-> !st_r[PPP_IN_ERR])
		else $error("error not settled");
	// ----------------------------------------
	// interrupt checks
	// ----------------------------------------
	chk_ack_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		ev[`PPP_IRQ_ACK] |=> ist_r[`PPP_IRQ_ACK])
		else $error("ack event lost");
	chk_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `PPP_OFF_IRQ_CLR && pwdata[`PPP_IRQ_ACK] && !ev[`PPP_IRQ_ACK]) |=> !ist_r[`PPP_IRQ_ACK])
		else $error("ack event not cleared");
	// ----------------------------------------
	// cover points
	// ----------------------------------------
	cov_ack_irq: cover property (@(posedge pclk) disable iff (!presetn) ev[`PPP_IRQ_ACK] ##1 irq);
	cov_strobe: cover property (@(posedge pclk) disable iff (!presetn) !data_strobe_n ##1 data_strobe_n);
	cov_bus_drive: cover property (@(posedge pclk) disable iff (!presetn) printer_data_bus_oe == 8'hFF);
	cov_paper: cover property (@(posedge pclk) disable iff (!presetn) ev[`PPP_IRQ_PAPER]);
	cov_error: cover property (@(posedge pclk) disable iff (!presetn) ev[`PPP_IRQ_ERROR] ##1 ist_r[`PPP_IRQ_ERROR]);
endmodule
`default_nettype wire

// >>> ppp_printer_model.sv
`timescale 1ns/1ns
`default_nettype none
// printer at the far end of the cable
module ppp_printer_model
(
	// pins from the port
	input wire logic pclk,
	input wire logic data_strobe_n,
	input wire logic select_request_n,
	// bench controls
	input wire logic paper_empty,
	input wire logic fault,
	// printer status pins
	output var logic printer_selected_in,
	output var logic paper_out_in,
	output var logic busy_in,
	output var logic ack_in_n,
	output var logic error_in_n
);
	logic strobe_q = 1'b1; // last strobe level
	logic [3:0] cnt = 4'h0; // busy then ack countdown
	// a falling strobe starts one character
	always @(posedge pclk)
	begin
		strobe_q <= data_strobe_n;
		if (strobe_q && !data_strobe_n)
			cnt <= 4'h8;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	assign printer_selected_in = !select_request_n;
	assign paper_out_in = paper_empty;
	assign busy_in = (cnt > 4'h2);
	assign ack_in_n = !(cnt == 4'h1 || cnt == 4'h2);
	assign error_in_n = !fault;
endmodule
`default_nettype wire

// >>> printer_parallel_port_pins_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppp_cfg.svh"
module printer_parallel_port_pins_tb_top;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, irq, paper_empty, fault;
	logic sel, paper, busy, ack_n, err_n, strb_n, lf_n, init_n, select_request_n_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pd_i, pd_o, pd_oe;
	int error_cnt = 0;
	int compares = 0;
	// printer drives its own byte while the port listens
	assign pd_i = (pd_oe != 8'h00) ? pd_o : 8'h3C;
	ppp_port ppp_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.printer_selected_in(sel), .paper_out_in(paper), .busy_in(busy), .ack_in_n(ack_n), .error_in_n(err_n),
		.data_strobe_n(strb_n), .line_feed_auto_n(lf_n), .init_out_n(init_n), .select_request_n(select_request_n_n),
		.printer_data_bus_i(pd_i), .printer_data_bus_o(pd_o), .printer_data_bus_oe(pd_oe), .irq(irq));
	ppp_printer_model ppp_printer_model_i (.pclk(pclk), .data_strobe_n(strb_n), .select_request_n(select_request_n_n),
		.paper_empty(paper_empty), .fault(fault), .printer_selected_in(sel), .paper_out_in(paper),
		.busy_in(busy), .ack_in_n(ack_n), .error_in_n(err_n));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	task close_out;
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one apb transfer, read data left in rd
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", 32'h0000_0000, 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task w8(input int k);
		repeat (k) @(posedge pclk);
		@(negedge pclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_ctrl;
		logic [3:0] v;
		chk("pins rst", 32'h0000_000F, 32'({strb_n, lf_n, init_n, select_request_n_n}));
		chk("oe rst", 32'h0000_0000, 32'({pd_oe, irq}));
		for (int i = 0; i < 16; i++)
		begin
			v = i[3:0];
			apb(1'b1, `PPP_OFF_CTRL, {28'h000_0000, v});
			w8(1);
			chk("pins", {28'h000_0000, ~v[0], ~v[1], v[2], ~v[3]}, 32'({strb_n, lf_n, init_n, select_request_n_n}));
		end
	endtask
	task t_bus;
		apb(1'b1, `PPP_OFF_DATA, 32'h0000_00A5);
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0044);
		w8(1);
		chk("bus out", 32'h0000_FFA5, 32'({pd_oe, pd_o}));
		apb(1'b0, `PPP_OFF_DATA, 32'h0000_0000);
		chk("data rd", 32'h0000_00A5, rd);
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0004);
		w8(1);
		chk("bus off", 32'h0000_0000, 32'(pd_oe));
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0064);
		apb(1'b0, `PPP_OFF_DATA, 32'h0000_0000);
		chk("bus in", 32'h0000_003C, rd);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
	endtask
	task t_status;
		@(posedge pclk);
		fault <= 1'b1;
		paper_empty <= 1'b1;
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_000C);
		w8(8);
		apb(1'b0, `PPP_OFF_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0070, rd);
		fault <= 1'b0;
		paper_empty <= 1'b0;
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_000D);
		while (busy !== 1'b1) @(posedge pclk);
		w8(4);
		apb(1'b0, `PPP_OFF_STATUS, 32'h0000_0000);
		chk("busy", 32'h0000_00D8, rd);
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0004);
		apb(1'b0, `PPP_OFF_IRQ_STAT, 32'h0000_0000);
		chk("irq events", 32'h0000_0007, rd);
	endtask
	task t_irq(input logic en);
		apb(1'b1, `PPP_OFF_IRQ_CLR, 32'h0000_0007);
		apb(1'b1, `PPP_OFF_IRQ_EN, {31'h0000_0000, en});
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0005);
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_0004);
		w8(20);
		chk("irq", {31'h0000_0000, en}, 32'(irq));
		apb(1'b0, `PPP_OFF_IRQ_STAT, 32'h0000_0000);
		chk("irq stat", 32'h0000_0001, rd);
		apb(1'b1, `PPP_OFF_IRQ_CLR, 32'h0000_0001);
		w8(1);
		chk("irq clr", 32'h0000_0000, 32'(irq));
	endtask
	// reset in mid-run returns pins and registers to idle
	task t_reset;
		apb(1'b1, `PPP_OFF_CTRL, 32'h0000_004A);
		presetn <= 1'b0;
		w8(2);
		chk("rst pins", 32'h0000_0F00, 32'({strb_n, lf_n, init_n, select_request_n_n, pd_oe}));
		chk("rst rd", 32'h0000_0000, prdata);
		chk("rst irq", 32'h0000_0000, 32'(irq));
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PPP_OFF_CTRL, 32'h0000_0000);
		chk("rst ctrl", 32'h0000_0004, rd);
	endtask
	initial
	begin
		#300000;
		error_cnt++;
		close_out;
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		paper_empty = 1'b0;
		fault = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		w8(1);
		t_ctrl;
		t_bus;
		t_status;
		t_irq(1'b1);
		t_irq(1'b0);
		t_reset;
		close_out;
	end
endmodule
`default_nettype wire
